// *** rtl/pewp_host.sv ***
/*
  Host controller for an asynchronous byte-wide EEPROM with page write,
  software write lock and toggle-bit end-of-write detection. Takes one
  request at a time on a valid/ready port and drives the memory pins.
  Assumes the memory data bus is asynchronous and the memory lines are
  wired straight to the pins with no other master.
*/

`timescale 1ns/100ps
`include "pewp_defs.svh"

module pewp_host #(
  parameter int BYTE_WINDOW_CYC = `PEWP_BYTE_WINDOW_CYC,
  parameter int PROG_TIMEOUT_CYC = `PEWP_PROG_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire pewp_pkg::pewp_op_type cmd_op,
  input wire logic [`PEWP_ADDR_W-1:0] cmd_addr,
  input wire logic [`PEWP_DATA_W-1:0] cmd_data,
  input wire logic cmd_prefix,
  input wire logic cmd_last,
  // answer
  output logic rsp_valid,
  output logic rsp_error,
  output logic [`PEWP_DATA_W-1:0] rsp_data,
  output logic lock_state,
  // memory pins
  output logic [`PEWP_ADDR_W-1:0] mem_addr,
  output logic [`PEWP_DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [`PEWP_DATA_W-1:0] mem_dq_in,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n
);
  import pewp_pkg::*;

  pewp_ctl_type st_reg;
  pewp_ctl_type st_next;

  logic pt_load;
  logic [`PEWP_PT_W-1:0] pt_val;
  logic pt_exp;
  logic wt_load;
  logic wt_exp;
  logic tt_load;
  logic tt_exp;
  logic [`PEWP_CMD_ADDR_W-1:0] seq_addr;
  logic [`PEWP_DATA_W-1:0] seq_data;
  logic toggle_now;
  logic settled;

  // lock command table; disable uses the six-byte form
  function automatic logic [`PEWP_CMD_ADDR_W+`PEWP_DATA_W-1:0] seq_byte(
    input logic off,
    input logic [`PEWP_SEQ_W-1:0] idx
  );
    logic [`PEWP_CMD_ADDR_W+`PEWP_DATA_W-1:0] r;
    r = {`PEWP_ON_A0, `PEWP_ON_D0};
    if (off) begin
      case (idx)
        3'h0: r = {`PEWP_OFF_A0, `PEWP_OFF_D0};
        3'h1: r = {`PEWP_OFF_A1, `PEWP_OFF_D1};
        3'h2: r = {`PEWP_OFF_A2, `PEWP_OFF_D2};
        3'h3: r = {`PEWP_OFF_A3, `PEWP_OFF_D3};
        3'h4: r = {`PEWP_OFF_A4, `PEWP_OFF_D4};
        default: r = {`PEWP_OFF_A5, `PEWP_OFF_D5};
      endcase
    end else begin
      case (idx)
        3'h0: r = {`PEWP_ON_A0, `PEWP_ON_D0};
        3'h1: r = {`PEWP_ON_A1, `PEWP_ON_D1};
        default: r = {`PEWP_ON_A2, `PEWP_ON_D2};
      endcase
    end
    return r;
  endfunction

  always_comb begin
    st_next = st_reg;
    pt_load = 1'b0;
    pt_val = '0;
    wt_load = 1'b0;
    tt_load = 1'b0;
    {seq_addr, seq_data} = seq_byte(st_reg.seq_off, st_reg.seq_idx);
    toggle_now = st_reg.din_s2[`PEWP_TOGGLE_BIT];
    settled = !st_reg.first_poll && (toggle_now == st_reg.tog_prev);
    // only the second stage is read by logic
    st_next.din_s1 = mem_dq_in;
    st_next.din_s2 = st_reg.din_s1;
    st_next.rsp_valid = 1'b0;
    st_next.rsp_error = 1'b0;

    case (st_reg.state)
      PEWP_IDLE: begin
        if (cmd_valid && st_reg.cmd_ready) begin
          st_next.cmd_ready = 1'b0;
          if (cmd_op == PEWP_OP_READ) begin
            st_next.addr = cmd_addr;
            st_next.ce_n = 1'b0;
            st_next.oe_n = 1'b0;
            pt_load = 1'b1;
            pt_val = `PEWP_PT_W'(`PEWP_ACCESS_CYC);
            st_next.state = PEWP_RD_ACCESS;
          end else begin
            st_next.seq_idx = '0;
            st_next.seq_off = (cmd_op == PEWP_OP_LOCK_OFF);
            if (cmd_op == PEWP_OP_LOCK_OFF) begin
              st_next.seq_len = `PEWP_SEQ_OFF_LEN;
            end else if (cmd_op == PEWP_OP_LOCK_ON || cmd_prefix) begin
              st_next.seq_len = `PEWP_SEQ_ON_LEN;
            end else begin
              st_next.seq_len = '0;
            end
            st_next.set_lock = (cmd_op == PEWP_OP_LOCK_ON) || (cmd_op == PEWP_OP_WRITE && cmd_prefix);
            st_next.clr_lock = (cmd_op == PEWP_OP_LOCK_OFF);
            st_next.have_data = (cmd_op == PEWP_OP_WRITE);
            st_next.data_addr = cmd_addr;
            st_next.data_byte = cmd_data;
            st_next.last_addr = cmd_addr;
            st_next.last = cmd_last;
            st_next.nbytes = '0;
            st_next.state = PEWP_ISSUE;
          end
        end
      end

      PEWP_ISSUE: begin
        if (st_reg.seq_idx != st_reg.seq_len) begin
          // command bytes keep the page's upper lines
          st_next.addr = {st_reg.data_addr[`PEWP_ADDR_MSB:`PEWP_CMD_ADDR_W], seq_addr};
          st_next.dout = seq_data;
          st_next.seq_idx = st_reg.seq_idx + `PEWP_SEQ_W'(1);
          st_next.doe = 1'b1;
          st_next.ce_n = 1'b0;
          st_next.oe_n = 1'b1;
          st_next.state = PEWP_WR_SETUP;
        end else if (st_reg.have_data) begin
          st_next.addr = st_reg.data_addr;
          st_next.dout = st_reg.data_byte;
          st_next.have_data = 1'b0;
          st_next.nbytes = st_reg.nbytes + `PEWP_DATA_W'(1);
          st_next.last_addr = st_reg.data_addr;
          st_next.doe = 1'b1;
          st_next.ce_n = 1'b0;
          st_next.oe_n = 1'b1;
          st_next.state = PEWP_WR_SETUP;
        end else if (st_reg.last || st_reg.nbytes == `PEWP_PAGE_MAX) begin
          // page closed: poll the last address until the toggle bit settles
          st_next.addr = st_reg.last_addr;
          st_next.ce_n = 1'b0;
          st_next.oe_n = 1'b0;
          st_next.first_poll = 1'b1;
          tt_load = 1'b1;
          pt_load = 1'b1;
          pt_val = `PEWP_PT_W'(`PEWP_ACCESS_CYC);
          st_next.state = PEWP_POLL_ACCESS;
        end else begin
          st_next.cmd_ready = 1'b1;
          st_next.state = PEWP_LOAD_WAIT;
        end
      end

      PEWP_WR_SETUP: begin
        st_next.we_n = 1'b0;
        pt_load = 1'b1;
        pt_val = `PEWP_PT_W'(`PEWP_WR_PULSE_CYC);
        st_next.state = PEWP_WR_PULSE;
      end

      PEWP_WR_PULSE: begin
        if (pt_exp) begin
          st_next.we_n = 1'b1;
          st_next.ce_n = 1'b1;
          wt_load = 1'b1;
          pt_load = 1'b1;
          pt_val = `PEWP_PT_W'(`PEWP_WR_HIGH_CYC);
          st_next.state = PEWP_WR_HIGH;
        end
      end

      PEWP_WR_HIGH: begin
        if (pt_exp) begin
          st_next.doe = 1'b0;
          st_next.state = PEWP_ISSUE;
        end
      end

      PEWP_LOAD_WAIT: begin
        if (cmd_valid && st_reg.cmd_ready) begin
          if (!wt_exp && cmd_op == PEWP_OP_WRITE && !cmd_prefix &&
              cmd_addr[`PEWP_ADDR_MSB:`PEWP_PAGE_LSB] == st_reg.data_addr[`PEWP_ADDR_MSB:`PEWP_PAGE_LSB]) begin
            st_next.cmd_ready = 1'b0;
            st_next.have_data = 1'b1;
            st_next.data_addr = cmd_addr;
            st_next.data_byte = cmd_data;
            st_next.last = cmd_last;
            st_next.state = PEWP_ISSUE;
          end else begin
            // foreign page or late byte is refused, never sent
            st_next.rsp_valid = 1'b1;
            st_next.rsp_error = 1'b1;
            if (wt_exp) begin
              st_next.cmd_ready = 1'b0;
              st_next.last = 1'b1;
              st_next.state = PEWP_ISSUE;
            end
          end
        end else if (wt_exp) begin
          st_next.cmd_ready = 1'b0;
          st_next.last = 1'b1;
          st_next.state = PEWP_ISSUE;
        end
      end

      PEWP_RD_ACCESS: begin
        if (pt_exp) begin
          st_next.rsp_valid = 1'b1;
          st_next.rsp_data = st_reg.din_s2;
          st_next.ce_n = 1'b1;
          st_next.oe_n = 1'b1;
          pt_load = 1'b1;
          pt_val = `PEWP_PT_W'(`PEWP_CE_HIGH_CYC);
          st_next.state = PEWP_RD_GAP;
        end
      end

      PEWP_RD_GAP: begin
        if (pt_exp) begin
          st_next.cmd_ready = 1'b1;
          st_next.state = PEWP_IDLE;
        end
      end

      PEWP_POLL_ACCESS: begin
        if (pt_exp) begin
          st_next.ce_n = 1'b1;
          st_next.oe_n = 1'b1;
          if (settled || tt_exp) begin
            // done on two equal samples or on the program timeout; the level itself means nothing
            st_next.rsp_valid = 1'b1;
            st_next.rsp_error = !settled;
            st_next.rsp_data = st_reg.din_s2;
            if (settled && st_reg.set_lock) begin
              st_next.locked = 1'b1;
            end else if (settled && st_reg.clr_lock) begin
              st_next.locked = 1'b0;
            end
            pt_load = 1'b1;
            pt_val = `PEWP_PT_W'(`PEWP_CE_HIGH_CYC);
            st_next.state = PEWP_RD_GAP;
          end else begin
            st_next.tog_prev = toggle_now;
            st_next.first_poll = 1'b0;
            pt_load = 1'b1;
            pt_val = `PEWP_PT_W'(`PEWP_OE_HIGH_CYC);
            st_next.state = PEWP_POLL_GAP;
          end
        end
      end

      PEWP_POLL_GAP: begin
        if (pt_exp) begin
          st_next.ce_n = 1'b0;
          st_next.oe_n = 1'b0;
          pt_load = 1'b1;
          pt_val = `PEWP_PT_W'(`PEWP_ACCESS_CYC);
          st_next.state = PEWP_POLL_ACCESS;
        end
      end

      default: begin
        st_next = PEWP_CTL_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= PEWP_CTL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // phase timing of strobes and reads
  pewp_timer #(.W(`PEWP_PT_W)) u_phase_timer (
    .clk(clk),
    .rst(rst),
    .load(pt_load),
    .value(pt_val),
    .expired(pt_exp)
  );

  // guard keeps the next strobe fall inside the load window
  pewp_timer #(.W(`PEWP_WT_W)) u_window_timer (
    .clk(clk),
    .rst(rst),
    .load(wt_load),
    .value(`PEWP_WT_W'(BYTE_WINDOW_CYC - `PEWP_WINDOW_GUARD)),
    .expired(wt_exp)
  );

  // a device that never settles is given up after the program time
  pewp_timer #(.W(`PEWP_TT_W)) u_prog_timer (
    .clk(clk),
    .rst(rst),
    .load(tt_load),
    .value(`PEWP_TT_W'(PROG_TIMEOUT_CYC)),
    .expired(tt_exp)
  );

  assign cmd_ready = st_reg.cmd_ready;
  assign rsp_valid = st_reg.rsp_valid;
  assign rsp_error = st_reg.rsp_error;
  assign rsp_data = st_reg.rsp_data;
  assign lock_state = st_reg.locked;
  assign mem_addr = st_reg.addr;
  assign mem_dq_out = st_reg.dout;
  assign mem_dq_oe = st_reg.doe;
  assign mem_ce_n = st_reg.ce_n;
  assign mem_oe_n = st_reg.oe_n;
  assign mem_we_n = st_reg.we_n;

endmodule

// *** common/pewp_defs.svh ***
/*
  Constants of the parallel EEPROM host controller: pin widths, field
  positions, timing figures with their cycle counts, and the lock command
  table. Assumes a 250 MHz controller clock.
*/
`ifndef PEWP_DEFS_SVH
`define PEWP_DEFS_SVH

// pin and field layout
`define PEWP_ADDR_W 17
`define PEWP_ADDR_MSB 16
`define PEWP_DATA_W 8
`define PEWP_CMD_ADDR_W 15
`define PEWP_PAGE_LSB 7
`define PEWP_TOGGLE_BIT 6
`define PEWP_PAGE_MAX 8'h80
`define PEWP_SEQ_W 3
`define PEWP_SEQ_ON_LEN 3'h3
`define PEWP_SEQ_OFF_LEN 3'h6

// timing figures, as printed, and their cycle counts
`define PEWP_CLK_NS 4
`define PEWP_WR_PULSE_NS 100
`define PEWP_WR_HIGH_NS 50
`define PEWP_CE_HIGH_NS 50
`define PEWP_OE_HIGH_NS 150
`define PEWP_ACCESS_NS 120
`define PEWP_SYNC_STAGES 2
`define PEWP_BYTE_WINDOW_US 150
`define PEWP_PROG_TIME_MS 10
`define PEWP_WINDOW_GUARD 4
`define PEWP_CEIL_CYC(ns) (((ns) + `PEWP_CLK_NS - 1) / `PEWP_CLK_NS)
`define PEWP_WR_PULSE_CYC `PEWP_CEIL_CYC(`PEWP_WR_PULSE_NS)
`define PEWP_WR_HIGH_CYC `PEWP_CEIL_CYC(`PEWP_WR_HIGH_NS)
`define PEWP_CE_HIGH_CYC `PEWP_CEIL_CYC(`PEWP_CE_HIGH_NS)
`define PEWP_OE_HIGH_CYC `PEWP_CEIL_CYC(`PEWP_OE_HIGH_NS)
`define PEWP_ACCESS_CYC (`PEWP_CEIL_CYC(`PEWP_ACCESS_NS) + `PEWP_SYNC_STAGES)
`define PEWP_BYTE_WINDOW_CYC ((`PEWP_BYTE_WINDOW_US * 1000) / `PEWP_CLK_NS)
`define PEWP_PROG_TIMEOUT_CYC ((`PEWP_PROG_TIME_MS * 1000000) / `PEWP_CLK_NS)
`define PEWP_PT_W 6
`define PEWP_WT_W 16
`define PEWP_TT_W 22

// lock command table: address on the low 15 lines, data byte
`define PEWP_ON_A0 15'h0001
`define PEWP_ON_D0 8'h01
`define PEWP_ON_A1 15'h0002
`define PEWP_ON_D1 8'h02
`define PEWP_ON_A2 15'h0003
`define PEWP_ON_D2 8'h03
`define PEWP_OFF_A0 15'h0001
`define PEWP_OFF_D0 8'h01
`define PEWP_OFF_A1 15'h0002
`define PEWP_OFF_D1 8'h02
`define PEWP_OFF_A2 15'h0003
`define PEWP_OFF_D2 8'h04
`define PEWP_OFF_A3 15'h0001
`define PEWP_OFF_D3 8'h05
`define PEWP_OFF_A4 15'h0002
`define PEWP_OFF_D4 8'h06
`define PEWP_OFF_A5 15'h0003
`define PEWP_OFF_D5 8'h07

`endif

// *** common/pewp_pkg.sv ***
/*
  Types of the parallel EEPROM host controller: request codes, sequencer
  states and the packed state record. Assumes pewp_defs.svh on the path.
*/
`include "pewp_defs.svh"

package pewp_pkg;

  typedef enum logic [1:0] {
    PEWP_OP_READ = 2'b00,
    PEWP_OP_WRITE = 2'b01,
    PEWP_OP_LOCK_ON = 2'b10,
    PEWP_OP_LOCK_OFF = 2'b11
  } pewp_op_type;

  typedef enum logic [3:0] {
    PEWP_IDLE = 4'b0000,
    PEWP_ISSUE = 4'b0001,
    PEWP_WR_SETUP = 4'b0010,
    PEWP_WR_PULSE = 4'b0011,
    PEWP_WR_HIGH = 4'b0100,
    PEWP_LOAD_WAIT = 4'b0101,
    PEWP_RD_ACCESS = 4'b0110,
    PEWP_RD_GAP = 4'b0111,
    PEWP_POLL_ACCESS = 4'b1000,
    PEWP_POLL_GAP = 4'b1001
  } pewp_state_type;

  typedef struct packed {
    pewp_state_type state;
    logic [`PEWP_ADDR_W-1:0] addr;
    logic [`PEWP_DATA_W-1:0] dout;
    logic doe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [`PEWP_DATA_W-1:0] din_s1;
    logic [`PEWP_DATA_W-1:0] din_s2;
    logic [`PEWP_SEQ_W-1:0] seq_idx;
    logic [`PEWP_SEQ_W-1:0] seq_len;
    logic seq_off;
    logic set_lock;
    logic clr_lock;
    logic have_data;
    logic last;
    logic [`PEWP_ADDR_W-1:0] data_addr;
    logic [`PEWP_DATA_W-1:0] data_byte;
    logic [`PEWP_ADDR_W-1:0] last_addr;
    logic [`PEWP_DATA_W-1:0] nbytes;
    logic first_poll;
    logic tog_prev;
    logic cmd_ready;
    logic rsp_valid;
    logic rsp_error;
    logic [`PEWP_DATA_W-1:0] rsp_data;
    logic locked;
  } pewp_ctl_type;

  parameter pewp_ctl_type PEWP_CTL_RESET = '{
    state: PEWP_IDLE,
    ce_n: 1'b1,
    oe_n: 1'b1,
    we_n: 1'b1,
    cmd_ready: 1'b1,
    default: '0
  };

endpackage

// *** rtl/pewp_timer.sv ***
/*
  Down counter used for every interval of the controller. A load sets the
  count; expired is high while the count is zero. Assumes one clock domain.
*/
`timescale 1ns/100ps

module pewp_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic expired
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } pewp_timer_type;

  pewp_timer_type st_reg;
  pewp_timer_type st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.cnt = value;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = (st_reg.cnt == '0);

endmodule

// *** dv/pewp_host_assertions.sv ***
/*
  Pin and answer-port checker of the EEPROM host controller.
  Assumes a bind to pewp_host; sees only its ports.
*/
`timescale 1ns/100ps
`include "pewp_defs.svh"

module pewp_host_assertions #(
  parameter int BYTE_WINDOW_CYC = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request and answer
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire pewp_pkg::pewp_op_type cmd_op,
  input wire logic [`PEWP_ADDR_W-1:0] cmd_addr,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  // memory pins
  input wire logic [`PEWP_ADDR_W-1:0] mem_addr,
  input wire logic mem_dq_oe,
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n
);
  import pewp_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [15:0] we_lo, we_hi, ce_hi, oe_hi;
  int gap;
  logic open_pg, poll_on;
  logic [9:0] pg;
  logic [`PEWP_ADDR_W-1:0] poll_a;

  // saturate high at reset: first fall passes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {we_lo, we_hi, ce_hi, oe_hi} <= {16'h0, {3{16'hffff}}};
      {gap, open_pg, poll_on, pg, poll_a} <= '0;
    end else begin
      we_lo <= mem_we_n ? 16'h0 : we_lo + 16'h1;
      we_hi <= mem_we_n ? we_hi + 16'(~&we_hi) : 16'h0;
      ce_hi <= mem_ce_n ? ce_hi + 16'(~&ce_hi) : 16'h0;
      oe_hi <= mem_oe_n ? oe_hi + 16'(~&oe_hi) : 16'h0;
      gap <= $rose(mem_we_n) ? 0 : gap + 1;
      if ($fell(mem_we_n)) begin
        open_pg <= 1'b1;
        pg <= mem_addr[16:7];
      end else if (!mem_oe_n) begin
        open_pg <= 1'b0;
      end
      if (rsp_valid) begin
        poll_on <= 1'b0;
      end else if ($fell(mem_oe_n) && open_pg) begin
        poll_on <= 1'b1;
        poll_a <= mem_addr;
      end
    end
  end

  a_write_strobes: assert property (!mem_we_n |-> mem_oe_n && !mem_ce_n && mem_dq_oe)
    else $error("bad strobes in write pulse");
  a_we_pulse_min: assert property ($rose(mem_we_n) |-> we_lo >= 16'h19)
    else $error("write pulse too short");
  a_we_high_min: assert property ($fell(mem_we_n) |-> we_hi >= 16'hd)
    else $error("write high too short");
  a_byte_window: assert property ($fell(mem_we_n) && open_pg |-> gap <= BYTE_WINDOW_CYC)
    else $error("byte load too late");
  a_read_ce_gap: assert property ($fell(mem_ce_n) && !mem_oe_n |-> ce_hi >= 16'hd)
    else $error("chip select gap too short");
  a_poll_gap: assert property ($fell(mem_oe_n) && poll_on |-> oe_hi >= 16'h26)
    else $error("poll gap too short");
  a_poll_addr: assert property ($fell(mem_oe_n) && poll_on |-> mem_addr == poll_a)
    else $error("poll address changed");
  a_page_refuse: assert property (cmd_valid && cmd_ready && open_pg && cmd_op == PEWP_OP_WRITE
    && cmd_addr[16:7] != pg |=> rsp_valid && rsp_error && mem_we_n && mem_ce_n)
    else $error("foreign page not refused");
  a_read_timing: assert property (cmd_valid && cmd_ready && cmd_op == PEWP_OP_READ && !open_pg
    |=> (!mem_ce_n && !mem_oe_n && mem_we_n && !mem_dq_oe && mem_addr == $past(cmd_addr))
    ##33 (rsp_valid && !rsp_error))
    else $error("read cycle wrong");
endmodule

bind pewp_host pewp_host_assertions #(.BYTE_WINDOW_CYC(BYTE_WINDOW_CYC)) u_pewp_host_assertions (
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .cmd_addr(cmd_addr), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
  .mem_addr(mem_addr), .mem_dq_oe(mem_dq_oe),
  .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n)
);

// *** dv/pewp_mem_model.sv ***
/*
  Behavioural byte-wide EEPROM: page load, write lock, polling status.
  Assumes the host is the only master; no clock.
*/
`timescale 1ns/100ps
`include "pewp_defs.svh"

module pewp_mem_model (
  // host pins
  input wire logic [16:0] a,
  input wire logic [7:0] dq_host,
  input wire logic dq_host_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [7:0] dq_wire,
  // bench view
  input wire logic [1:0] speed,
  output logic locked,
  output logic active,
  output logic [7:0] viol
);
  logic [22:0] on_t [0:2], off_t [0:5];
  logic [7:0] mem [0:131071];
  logic [7:0] q, junk, last_d;
  logic [16:0] la;
  logic [16:0] pa [$];
  logic [7:0] pd [$];
  logic armed, busy, loading, tog, q_ok;
  realtime t_wf, t_wr, t_ce, ce_gap;

  initial begin
    on_t = '{{`PEWP_ON_A0, `PEWP_ON_D0}, {`PEWP_ON_A1, `PEWP_ON_D1}, {`PEWP_ON_A2, `PEWP_ON_D2}};
    off_t = '{{`PEWP_OFF_A0, `PEWP_OFF_D0}, {`PEWP_OFF_A1, `PEWP_OFF_D1}, {`PEWP_OFF_A2, `PEWP_OFF_D2},
      {`PEWP_OFF_A3, `PEWP_OFF_D3}, {`PEWP_OFF_A4, `PEWP_OFF_D4}, {`PEWP_OFF_A5, `PEWP_OFF_D5}};
    foreach (mem[i]) mem[i] = 8'hff;
    {armed, busy, loading, tog, q_ok, locked} = 6'h0;
    viol = 8'h0;
    junk = 8'h5a;
    last_d = 8'h0;
    t_wr = 0;
    t_ce = -1000;
    ce_gap = 1000;
  end

  // moving junk: a stale sample never matches
  always #3 junk = ~junk;
  assign active = busy | loading;
  assign dq_wire = dq_host_oe ? dq_host : (q_ok && !ce_n && !oe_n) ? q : junk;

  always @(negedge we_n) begin
    if (loading && $realtime - t_wr < 50) viol++;
    armed = !ce_n && oe_n && !busy;
    t_wf = $realtime;
    la = a;
  end
  always @(negedge oe_n) if (armed) begin
    armed = 0;
    viol++;
  end
  always @(posedge we_n or posedge ce_n) if (armed) begin
    armed = 0;
    t_wr = $realtime;
    if ($realtime - t_wf >= 15) begin
      if ($realtime - t_wf < 100) viol++;
      pa.push_back(la);
      pd.push_back(dq_host);
      loading = 1;
    end
  end

  task automatic commit();
    int n;
    logic on, off;
    busy = 1;
    loading = 0;
    on = pa.size() >= 3;
    off = pa.size() >= 6;
    for (int i = 0; i < 6; i++) begin
      if (i < 3 && (i >= pa.size() || {pa[i][14:0], pd[i]} != on_t[i])) on = 0;
      if (i >= pa.size() || {pa[i][14:0], pd[i]} != off_t[i]) off = 0;
    end
    n = off ? 6 : on ? 3 : 0;
    last_d = pd[pd.size() - 1];
    for (int i = n; i < pa.size(); i++) if (pa[i][16:7] != pa[n][16:7]) viol++;
    #(speed == 2'h0 ? 400 : speed == 2'h1 ? 6000 : 20000);
    if (!(locked && n == 0)) for (int i = n; i < pa.size(); i++) mem[pa[i]] = pd[i];
    if (off) locked = 0;
    else if (on) locked = 1;
    pa.delete();
    pd.delete();
    busy = 0;
  endtask

  always #10 if (loading && $realtime - t_wr >= 1000) commit();

  always @(posedge ce_n) t_ce = $realtime;
  always @(negedge ce_n) ce_gap = $realtime - t_ce;
  always @(negedge oe_n or negedge ce_n) begin
    q_ok = 0;
    #0.1;
    if (!ce_n && !oe_n && we_n) begin
      if (ce_gap < 50) viol++;
      if (active) begin
        tog = ~tog;
        q = {~last_d[7], tog, junk[5:0]};
      end else begin
        q = mem[a];
      end
      #120 q_ok = !ce_n && !oe_n;
    end
  end
endmodule

// *** dv/parallel_eeprom_write_protect_poll_tb.sv ***
/*
  Self-checking bench of the EEPROM host controller against the memory model.
  Assumes design, checker and model compile first.
*/
`timescale 1ns/100ps
`include "pewp_defs.svh"

module parallel_eeprom_write_protect_poll_tb;
  import pewp_pkg::*;
  logic clk, rst, cmd_valid, cmd_ready, cmd_prefix, cmd_last, rsp_valid, rsp_error, lock_state;
  logic mem_dq_oe, mem_ce_n, mem_oe_n, mem_we_n, locked, active, lk;
  pewp_op_type cmd_op;
  logic [16:0] cmd_addr, mem_addr, a;
  logic [7:0] cmd_data, rsp_data, mem_dq_out, mem_dq_in, viol, got;
  logic [1:0] speed;
  logic [7:0] exp_mem [int];
  int err_total, n_checks, n;

  pewp_host #(.BYTE_WINDOW_CYC(200), .PROG_TIMEOUT_CYC(2000)) u_pewp_host (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_prefix(cmd_prefix), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_data(rsp_data), .lock_state(lock_state), .mem_addr(mem_addr),
    .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in), .mem_ce_n(mem_ce_n),
    .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n));
  pewp_mem_model u_pewp_mem_model (.a(mem_addr), .dq_host(mem_dq_out), .dq_host_oe(mem_dq_oe),
    .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .dq_wire(mem_dq_in), .speed(speed),
    .locked(locked), .active(active), .viol(viol));

  task automatic chk8(string what, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(string what, logic e, logic g);
    chk8(what, {7'h0, e}, {7'h0, g});
  endtask

  task automatic req(pewp_op_type op, logic [16:0] ad, logic [7:0] d, logic pf, logic lst);
    int k;
    @(negedge clk);
    cmd_op = op;
    {cmd_addr, cmd_data, cmd_prefix, cmd_last, cmd_valid} = {ad, d, pf, lst, 1'b1};
    for (k = 0; cmd_ready !== 1'b1 && k < 5000; k++) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 0;
  endtask

  task automatic get_rsp(logic e_err);
    int k;
    for (k = 0; rsp_valid !== 1'b1 && k < 20000; k++) @(negedge clk);
    chk1("rsp_valid", 1'b1, rsp_valid);
    chk1("rsp_error", e_err, rsp_error);
    got = rsp_data;
  endtask

  task automatic rd_chk(logic [16:0] ad);
    req(PEWP_OP_READ, ad, 8'h0, 1'b0, 1'b0);
    get_rsp(1'b0);
    chk8("read data", exp_mem.exists(ad) ? exp_mem[ad] : 8'hff, got);
  endtask

  // bytes wrap in the page; locked device keeps old data unless prefixed
  task automatic wr_page(logic [16:0] base, int cnt, logic pf);
    logic [7:0] d;
    logic [16:0] ad;
    for (int i = 0; i < cnt; i++) begin
      d = 8'($urandom);
      ad = {base[16:7], base[6:0] + 7'(i)};
      req(PEWP_OP_WRITE, ad, d, pf && i == 0, i == cnt - 1);
      if (!lk || pf) exp_mem[ad] = d;
    end
    get_rsp(1'b0);
    chk1("device idle", 1'b0, active);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  // whole run is about 25k cycles
  initial begin
    #(90000 * 4);
    err_total++;
    give_verdict();
  end

  initial begin
    {rst, cmd_valid, cmd_prefix, cmd_last, lk} = 5'h10;
    cmd_op = PEWP_OP_READ;
    {cmd_addr, cmd_data} = '0;
    speed = 2'h0;
    repeat (5) @(negedge clk);
    rst = 0;
    void'($urandom(79784));
    for (int t = 0; t < 8; t++) begin
      a = 17'($urandom_range(17'h1ffff, 17'h80));
      n = t == 0 ? 128 : $urandom_range(8, 1);
      wr_page(a, n, 1'b0);
      rd_chk({a[16:7], a[6:0] + 7'(n - 1)});
      rd_chk({a[16:7], a[6:0]});
    end
    $display("test random pages done");
    req(PEWP_OP_WRITE, 17'h00300, 8'h11, 1'b0, 1'b0);
    exp_mem[17'h00300] = 8'h11;
    req(PEWP_OP_WRITE, 17'h00380, 8'h22, 1'b0, 1'b1);
    get_rsp(1'b1);
    req(PEWP_OP_READ, 17'h00300, 8'h0, 1'b0, 1'b0);
    get_rsp(1'b1);
    wr_page(17'h00301, 1, 1'b0);
    rd_chk(17'h00380);
    rd_chk(17'h00300);
    wr_page(17'h00400, 1, 1'b0);
    wr_page(17'h00410, 2, 1'b0);
    rd_chk(17'h00400);
    $display("test refusal done");
    req(PEWP_OP_LOCK_ON, 17'h0, 8'h0, 1'b0, 1'b1);
    get_rsp(1'b0);
    lk = 1;
    chk1("lock_state", 1'b1, lock_state);
    chk1("device locked", 1'b1, locked);
    wr_page(17'h00500, 2, 1'b0);
    rd_chk(17'h00501);
    wr_page(17'h00600, 3, 1'b1);
    rd_chk(17'h00600);
    req(PEWP_OP_LOCK_ON, 17'h0, 8'h0, 1'b0, 1'b0);
    req(PEWP_OP_WRITE, 17'h00010, 8'h5c, 1'b0, 1'b1);
    exp_mem[17'h00010] = 8'h5c;
    get_rsp(1'b0);
    rd_chk(17'h00010);
    for (int i = 1; i < 4; i++) rd_chk(17'(i));
    req(PEWP_OP_LOCK_OFF, 17'h0, 8'h0, 1'b0, 1'b1);
    get_rsp(1'b0);
    lk = 0;
    chk1("lock_state", 1'b0, lock_state);
    chk1("device locked", 1'b0, locked);
    wr_page(17'h00500, 2, 1'b0);
    rd_chk(17'h00501);
    $display("test write lock done");
    speed = 2'h1;
    wr_page(17'h00700, 4, 1'b0);
    rd_chk(17'h00703);
    speed = 2'h2;
    req(PEWP_OP_WRITE, 17'h00800, 8'h3c, 1'b0, 1'b1);
    exp_mem[17'h00800] = 8'h3c;
    get_rsp(1'b1);
    while (active === 1'b1) @(negedge clk);
    speed = 2'h0;
    rd_chk(17'h00800);
    for (int i = 0; i < 6; i++) rd_chk(17'($urandom));
    chk8("host timing faults", 8'h0, viol);
    $display("test slow device done");
    give_verdict();
  end
endmodule
